/* verilog/asramc_pkg.sv */
package asramc_pkg;

    // bus geometry
    localparam int ADDR_W      = 18;
    localparam int DATA_W      = 16;
    localparam int LANES       = 2;
    localparam int SYNC_STAGES = 2;
    localparam int TMR_W       = 8;

    // clock
    localparam int CLK_PERIOD_NS = 100;

    // memory timing figures in ns, faster and slower grade
    localparam int T_RC_FAST_NS = 55;
    localparam int T_RC_SLOW_NS = 70;
    localparam int T_AA_FAST_NS = 55;
    localparam int T_AA_SLOW_NS = 70;
    localparam int T_WP_FAST_NS = 40;
    localparam int T_WP_SLOW_NS = 50;
    localparam int T_AW_FAST_NS = 50;
    localparam int T_AW_SLOW_NS = 60;
    localparam int T_CW_FAST_NS = 50;
    localparam int T_CW_SLOW_NS = 60;
    localparam int T_BW_FAST_NS = 50;
    localparam int T_BW_SLOW_NS = 55;
    localparam int T_DW_FAST_NS = 25;
    localparam int T_DW_SLOW_NS = 30;

    // least time to whole cycles, never below one
    function automatic int ceil_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int max3(input int a, input int b, input int c);
        int m;
        m = (a > b) ? a : b;
        return (m > c) ? m : c;
    endfunction

    // derived cycle counts
    localparam int RD_CYC_FAST   = max3(ceil_cyc(T_AA_FAST_NS), ceil_cyc(T_RC_FAST_NS), 1);
    localparam int RD_CYC_SLOW   = max3(ceil_cyc(T_AA_SLOW_NS), ceil_cyc(T_RC_SLOW_NS), 1);
    localparam int RC_CYC_FAST   = ceil_cyc(T_RC_FAST_NS);
    localparam int RC_CYC_SLOW   = ceil_cyc(T_RC_SLOW_NS);
    localparam int WP_CYC_FAST   = ceil_cyc(T_WP_FAST_NS);
    localparam int WP_CYC_SLOW   = ceil_cyc(T_WP_SLOW_NS);
    localparam int PRE_CYC_FAST  = max3(ceil_cyc(T_AW_FAST_NS), ceil_cyc(T_CW_FAST_NS), ceil_cyc(T_BW_FAST_NS));
    localparam int PRE_CYC_SLOW  = max3(ceil_cyc(T_AW_SLOW_NS), ceil_cyc(T_CW_SLOW_NS), ceil_cyc(T_BW_SLOW_NS));
    localparam int DW_CYC_FAST   = ceil_cyc(T_DW_FAST_NS);
    localparam int DW_CYC_SLOW   = ceil_cyc(T_DW_SLOW_NS);

    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [LANES-1:0]  be;
    } asramc_req_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              chip_select_active_low;
        logic              chip_select_active_high;
        logic              output_enable_n;
        logic              write_strobe_n;
        logic              high_byte_lane_select_n;
        logic              low_byte_lane_select_n;
    } asramc_pins_t;

    // pins after reset and between accesses: deselected, high select held firm
    localparam asramc_pins_t PINS_IDLE = '{addr: 18'h00000, chip_select_active_low: 1'b1,
        chip_select_active_high: 1'b1, output_enable_n: 1'b1, write_strobe_n: 1'b1,
        high_byte_lane_select_n: 1'b1, low_byte_lane_select_n: 1'b1};

    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_RD    = 7'h02,
        ST_WSET  = 7'h04,
        ST_WPUL  = 7'h08,
        ST_WEND  = 7'h10,
        ST_RET   = 7'h20,
        ST_RECOV = 7'h40
    } asramc_state_t;

endpackage

/* verilog/asramc_sync.sv */
`timescale 1ns/1ps
module asramc_sync #(
    parameter int W = 16
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;

    // two flops per pin bit, first stage feeds only the second
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                s1_q[i] <= 1'b0;
                s2_q[i] <= 1'b0;
            end else begin
                s1_q[i] <= din[i];
                s2_q[i] <= s1_q[i];
            end
        end
    end

    assign dout = s2_q;
endmodule // asramc_sync

/* verilog/asramc_timer.sv */
`timescale 1ns/1ps
module asramc_timer (
    input  wire logic                         mclk,
    input  wire logic                         rst,
    input  wire logic                         load,
    input  wire logic [asramc_pkg::TMR_W-1:0] val,
    output logic                              done
);
    logic [asramc_pkg::TMR_W-1:0] cnt_q;
    logic [asramc_pkg::TMR_W-1:0] cnt_d;

    // load wins, otherwise count down to zero and rest there
    always_comb begin
        cnt_d = cnt_q;
        if (load) begin
            cnt_d = val;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign done = (cnt_q == '0);
endmodule // asramc_timer

/* verilog/asramc_ctrl.sv */
`timescale 1ns/1ps
// Summary of operation
// - write spans last assert to first release
// - write strobe low for minimum pulse
// - address valid long before write end
// - chip selects active long before write end
// - byte lanes asserted long before write end
// - address set before write starts
// - address held through write end
// - data set before end, held after
// - retention entered by dropping high select
// - high select driven firmly at all times
// - deselect before supply falls
module asramc_ctrl #(
    parameter bit FAST_GRADE = 1'b0
) (
    input  wire logic                              mclk,
    input  wire logic                              rst,
    input  wire logic                              req_valid,
    output logic                                   req_ready,
    input  wire asramc_pkg::asramc_req_t           req,
    output logic                                   rsp_valid,
    output logic      [asramc_pkg::DATA_W-1:0]     rsp_rdata,
    input  wire logic                              ret_req,
    output logic                                   ret_ready,
    output asramc_pkg::asramc_pins_t               pins,
    output logic      [asramc_pkg::DATA_W-1:0]     dq_o,
    output logic      [asramc_pkg::LANES-1:0]      dq_oe,
    input  wire logic [asramc_pkg::DATA_W-1:0]     dq_i
);
    // grade dependent counts
    localparam int RD_CYC  = FAST_GRADE ? asramc_pkg::RD_CYC_FAST : asramc_pkg::RD_CYC_SLOW;
    localparam int RC_CYC  = FAST_GRADE ? asramc_pkg::RC_CYC_FAST : asramc_pkg::RC_CYC_SLOW;
    localparam int WP_CYC  = FAST_GRADE ? asramc_pkg::WP_CYC_FAST : asramc_pkg::WP_CYC_SLOW;
    localparam int PRE_CYC = FAST_GRADE ? asramc_pkg::PRE_CYC_FAST : asramc_pkg::PRE_CYC_SLOW;
    localparam int DW_CYC  = FAST_GRADE ? asramc_pkg::DW_CYC_FAST : asramc_pkg::DW_CYC_SLOW;
    // setup phase makes the select-to-end and data-to-end spans
    localparam int SET_A   = PRE_CYC - WP_CYC;
    localparam int SET_B   = DW_CYC - WP_CYC;
    localparam int SET_M   = (SET_A > SET_B) ? SET_A : SET_B;
    localparam int SET_CYC = (SET_M < 1) ? 1 : SET_M;
    // read holds pins through access plus synchroniser latency
    localparam int RD_HOLD = RD_CYC + asramc_pkg::SYNC_STAGES;

    localparam logic [asramc_pkg::TMR_W-1:0] RD_LOAD  = asramc_pkg::TMR_W'(RD_HOLD - 1);
    localparam logic [asramc_pkg::TMR_W-1:0] SET_LOAD = asramc_pkg::TMR_W'(SET_CYC - 1);
    localparam logic [asramc_pkg::TMR_W-1:0] WP_LOAD  = asramc_pkg::TMR_W'(WP_CYC - 1);
    localparam logic [asramc_pkg::TMR_W-1:0] RC_LOAD  = asramc_pkg::TMR_W'(RC_CYC - 1);

    // user lane enables to active-low lane selects, bit 0 is the low lane
    function automatic logic [asramc_pkg::LANES-1:0] lane_sel_n(input logic [asramc_pkg::LANES-1:0] be);
        return ~be;
    endfunction

    // lane enables widened to a data mask
    function automatic logic [asramc_pkg::DATA_W-1:0] lane_mask(input logic [asramc_pkg::LANES-1:0] be);
        return {{8{be[1]}}, {8{be[0]}}};
    endfunction

    asramc_pkg::asramc_state_t          state_q;
    asramc_pkg::asramc_state_t          state_d;
    asramc_pkg::asramc_pins_t           pins_q;
    asramc_pkg::asramc_pins_t           pins_d;
    asramc_pkg::asramc_req_t            req_q;
    asramc_pkg::asramc_req_t            req_d;
    logic [asramc_pkg::DATA_W-1:0]      dq_o_q;
    logic [asramc_pkg::DATA_W-1:0]      dq_o_d;
    logic [asramc_pkg::LANES-1:0]       dq_oe_q;
    logic [asramc_pkg::LANES-1:0]       dq_oe_d;
    logic [asramc_pkg::DATA_W-1:0]      rdata_q;
    logic [asramc_pkg::DATA_W-1:0]      rdata_d;
    logic                               rsp_valid_q;
    logic                               rsp_valid_d;
    logic                               ret_ready_q;
    logic                               ret_ready_d;
    logic                               tmr_load;
    logic [asramc_pkg::TMR_W-1:0]       tmr_val;
    logic                               tmr_done;
    logic [asramc_pkg::DATA_W-1:0]      dq_sync;

    // data pins come from outside the clock domain
    asramc_sync #(
        .W    (asramc_pkg::DATA_W)
    ) u_sync (
        .mclk (mclk),
        .rst  (rst),
        .din  (dq_i),
        .dout (dq_sync)
    );

    // one phase timer shared by the read, write setup, write pulse and recovery phases
    asramc_timer u_timer (
        .mclk (mclk),
        .rst  (rst),
        .load (tmr_load),
        .val  (tmr_val),
        .done (tmr_done)
    );

    // accept only when idle and no retention pending
    assign req_ready = (state_q == asramc_pkg::ST_IDLE) && !ret_req;

    // sequencer next state and pin values
    always_comb begin
        state_d     = state_q;
        pins_d      = pins_q;
        req_d       = req_q;
        dq_o_d      = dq_o_q;
        dq_oe_d     = dq_oe_q;
        rdata_d     = rdata_q;
        rsp_valid_d = 1'b0;
        ret_ready_d = ret_ready_q;
        tmr_load    = 1'b0;
        tmr_val     = '0;
        case (state_q)
            asramc_pkg::ST_IDLE: begin
                pins_d  = asramc_pkg::PINS_IDLE;
                dq_oe_d = '0;
                if (ret_req) begin
                    // drop the high select: it gates every other input
                    pins_d.chip_select_active_high = 1'b0;
                    ret_ready_d                    = 1'b1;
                    state_d                        = asramc_pkg::ST_RET;
                end else if (req_valid) begin
                    req_d = req;
                    if (req.be == '0) begin
                        // no lane selected: standby, nothing stored or read
                        rdata_d     = '0;
                        rsp_valid_d = 1'b1;
                    end else begin
                        pins_d.addr                    = req.addr;
                        pins_d.chip_select_active_low  = 1'b0;
                        pins_d.chip_select_active_high = 1'b1;
                        {pins_d.high_byte_lane_select_n,
                         pins_d.low_byte_lane_select_n} = lane_sel_n(req.be);
                        tmr_load = 1'b1;
                        if (req.write) begin
                            // outputs are off since idle, so drive data now
                            pins_d.output_enable_n = 1'b1;
                            dq_o_d   = req.wdata;
                            dq_oe_d  = req.be;
                            tmr_val  = SET_LOAD;
                            state_d  = asramc_pkg::ST_WSET;
                        end else begin
                            pins_d.output_enable_n = 1'b0;
                            tmr_val  = RD_LOAD;
                            state_d  = asramc_pkg::ST_RD;
                        end
                    end
                end
            end
            asramc_pkg::ST_RD: begin
                // pins stay put until the synchronised data is settled
                if (tmr_done) begin
                    rdata_d     = dq_sync & lane_mask(req_q.be);
                    rsp_valid_d = 1'b1;
                    pins_d      = asramc_pkg::PINS_IDLE;
                    state_d     = asramc_pkg::ST_IDLE;
                end
            end
            asramc_pkg::ST_WSET: begin
                // address, selects and data settle before the strobe
                if (tmr_done) begin
                    pins_d.write_strobe_n = 1'b0;
                    tmr_load = 1'b1;
                    tmr_val  = WP_LOAD;
                    state_d  = asramc_pkg::ST_WPUL;
                end
            end
            asramc_pkg::ST_WPUL: begin
                // strobe rise is the first release and ends the write
                if (tmr_done) begin
                    pins_d.write_strobe_n = 1'b1;
                    state_d = asramc_pkg::ST_WEND;
                end
            end
            asramc_pkg::ST_WEND: begin
                // data held one cycle and address two cycles past the write end
                pins_d      = asramc_pkg::PINS_IDLE;
                pins_d.addr = pins_q.addr;
                dq_oe_d     = '0;
                rsp_valid_d = 1'b1;
                state_d     = asramc_pkg::ST_IDLE;
            end
            asramc_pkg::ST_RET: begin
                // supply is back once the retention request falls
                if (!ret_req) begin
                    pins_d.chip_select_active_high = 1'b1;
                    ret_ready_d = 1'b0;
                    tmr_load    = 1'b1;
                    tmr_val     = RC_LOAD;
                    state_d     = asramc_pkg::ST_RECOV;
                end
            end
            asramc_pkg::ST_RECOV: begin
                // stay deselected for one read cycle time
                if (tmr_done) begin
                    state_d = asramc_pkg::ST_IDLE;
                end
            end
            default: begin
                pins_d      = asramc_pkg::PINS_IDLE;
                dq_oe_d     = '0;
                ret_ready_d = 1'b0;
                state_d     = asramc_pkg::ST_IDLE;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q     <= asramc_pkg::ST_IDLE;
            pins_q      <= asramc_pkg::PINS_IDLE;
            req_q       <= '0;
            dq_o_q      <= '0;
            dq_oe_q     <= '0;
            rdata_q     <= '0;
            rsp_valid_q <= 1'b0;
            ret_ready_q <= 1'b0;
        end else begin
            state_q     <= state_d;
            pins_q      <= pins_d;
            req_q       <= req_d;
            dq_o_q      <= dq_o_d;
            dq_oe_q     <= dq_oe_d;
            rdata_q     <= rdata_d;
            rsp_valid_q <= rsp_valid_d;
            ret_ready_q <= ret_ready_d;
        end
    end

    // outputs straight from flops
    assign pins      = pins_q;
    assign dq_o      = dq_o_q;
    assign dq_oe     = dq_oe_q;
    assign rsp_valid = rsp_valid_q;
    assign rsp_rdata = rdata_q;
    assign ret_ready = ret_ready_q;
endmodule // asramc_ctrl

/* verif/asramc_ctrl_sva.sv */
`timescale 1ns/1ps
module asramc_ctrl_sva (
    input wire logic                     mclk,
    input wire logic                     rst,
    input wire logic                     req_valid,
    input wire logic                     req_ready,
    input wire asramc_pkg::asramc_req_t  req,
    input wire logic                     rsp_valid,
    input wire logic                     ret_req,
    input wire logic                     ret_ready,
    input wire asramc_pkg::asramc_pins_t pins,
    input wire logic [15:0]              dq_o,
    input wire logic [1:0]               dq_oe
);
    logic       we_n;
    logic       cs1_n;
    logic       cs2;
    logic       oe_n;
    logic [1:0] lanes_n;
    logic       take;

    // short views of the pin struct and of a taken lane request
    assign we_n    = pins.write_strobe_n;
    assign cs1_n   = pins.chip_select_active_low;
    assign cs2     = pins.chip_select_active_high;
    assign oe_n    = pins.output_enable_n;
    assign lanes_n = {pins.high_byte_lane_select_n, pins.low_byte_lane_select_n};
    assign take    = req_valid && req_ready && (req.be != 2'b00);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    rd_seq_a: assert property (take && !req.write |=> (!oe_n && !cs1_n && lanes_n == ~$past(req.be))
        ##1 (!oe_n && $stable(pins.addr))[*2] ##1 rsp_valid) else $error("read cycle shape wrong");
    wr_seq_a: assert property (take && req.write |=> we_n && !cs1_n ##1 !we_n ##1 we_n ##1 rsp_valid)
        else $error("write strobe shape wrong");
    wr_addr_a: assert property (!we_n |=> $stable(pins.addr) && !cs1_n)
        else $error("address moved at write end");
    wr_setup_a: assert property ($fell(we_n) |-> !$past(cs1_n) && cs2 && $stable(pins.addr) && $stable(lanes_n))
        else $error("write started without setup");
    lane_a: assert property (!we_n |-> lanes_n != 2'b11 && dq_oe == ~lanes_n)
        else $error("lane selects disagree with drive");
    data_a: assert property ($rose(we_n) && !cs1_n |-> $stable(dq_o) && dq_oe != 2'b00)
        else $error("write data not held to write end");
    no_fight_a: assert property (dq_oe != 2'b00 |-> oe_n)
        else $error("host drives while outputs enabled");
    drive_gap_a: assert property (dq_oe != 2'b00 && $past(dq_oe) == 2'b00 |-> $past(oe_n))
        else $error("drive started right after output enable");
    ret_in_a: assert property ($rose(ret_ready) |-> $past(ret_req) && !cs2)
        else $error("retention flag without deselect");
    firm_sel_a: assert property (!ret_ready |-> cs2)
        else $error("high select low outside retention");
    recov_a: assert property ($fell(ret_ready) |-> !req_ready)
        else $error("no recovery after retention");

    read_c: cover property (take && !req.write);
    write_c: cover property (take && req.write);
    ret_c: cover property ($fell(ret_ready));
endmodule // asramc_ctrl_sva

bind asramc_ctrl asramc_ctrl_sva i_asramc_ctrl_sva (.mclk(mclk), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .ret_req(ret_req), .ret_ready(ret_ready),
    .pins(pins), .dq_o(dq_o), .dq_oe(dq_oe));

/* verif/asramc_mem_model.sv */
`timescale 1ns/1ps
module asramc_mem_model #(
    parameter bit FAST_GRADE = 1'b0
) (
    input  wire asramc_pkg::asramc_pins_t pins,
    input  wire logic [15:0]              dq_o,
    input  wire logic [1:0]               dq_oe,
    output logic      [15:0]              dq_i
);
    localparam int T_ACC = FAST_GRADE ? 55 : 70;
    localparam int T_HZ  = FAST_GRADE ? 20 : 25;
    logic [15:0] mem [logic [17:0]];
    logic [15:0] mem_rd;
    logic [15:0] last_q = 16'h0000;
    logic [15:0] old;
    logic [1:0]  on_q = 2'b00;
    logic [1:0]  lane_on;
    logic [1:0]  rd_en;
    logic        sel;
    logic        wr;

    // selection, lanes, write and read qualification
    assign sel     = !pins.chip_select_active_low && pins.chip_select_active_high;
    assign lane_on = ~{pins.high_byte_lane_select_n, pins.low_byte_lane_select_n};
    assign wr      = sel && !pins.write_strobe_n && (lane_on != 2'b00);
    assign rd_en   = (sel && !pins.output_enable_n && pins.write_strobe_n) ? lane_on : 2'b00;

    // lanes show data after access time and let go within turn-off time
    always @(rd_en) on_q <= #(rd_en != 2'b00 ? T_ACC : T_HZ) rd_en;

    // array lookup and store of the selected lanes
    always @(pins or wr) mem_rd = mem.exists(pins.addr) ? mem[pins.addr] : 16'h0000;
    always @(wr or dq_i or pins) begin
        if (wr) begin
            old = mem.exists(pins.addr) ? mem[pins.addr] : 16'h0000;
            mem[pins.addr] = {lane_on[1] ? dq_i[15:8] : old[15:8], lane_on[0] ? dq_i[7:0] : old[7:0]};
        end
    end

    // bus level per lane; a released lane shows the inverse of its last value
    always @(dq_o or dq_oe or on_q or mem_rd) begin
        for (int i = 0; i < 2; i++) begin
            if (dq_oe[i]) last_q[i*8 +: 8] = dq_o[i*8 +: 8];
            else if (on_q[i]) last_q[i*8 +: 8] = mem_rd[i*8 +: 8];
            dq_i[i*8 +: 8] = (dq_oe[i] || on_q[i]) ? last_q[i*8 +: 8] : ~last_q[i*8 +: 8];
        end
    end
endmodule // asramc_mem_model

/* verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic                     mclk;
    logic                     rst;
    logic                     req_valid;
    logic                     req_ready;
    asramc_pkg::asramc_req_t  req;
    logic                     rsp_valid;
    logic [15:0]              rsp_rdata;
    logic                     ret_req;
    logic                     ret_ready;
    asramc_pkg::asramc_pins_t pins;
    logic [15:0]              dq_o;
    logic [1:0]               dq_oe;
    logic [15:0]              dq_i;
    int                       n_errors;
    int                       checked;
    int                       ref_mem [int];

    asramc_ctrl #(.FAST_GRADE(1'b0)) i_asramc_ctrl (.mclk(mclk), .rst(rst), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .ret_req(ret_req),
        .ret_ready(ret_ready), .pins(pins), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i));
    asramc_mem_model #(.FAST_GRADE(1'b0)) i_asramc_mem_model (.pins(pins), .dq_o(dq_o), .dq_oe(dq_oe),
        .dq_i(dq_i));

    // bench clock
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (n_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // one request, entered at a falling edge so calls can run back to back
    task automatic access(input logic w, input logic [17:0] a, input logic [15:0] d, input logic [1:0] be);
        int n;
        int m;
        m = ref_mem.exists(a) ? ref_mem[a] : 0;
        req_valid = 1'b1;
        req = '{write: w, addr: a, wdata: d, be: be};
        n = 0;
        while (req_ready !== 1'b1 && n < 20) begin
            @(negedge mclk);
            n++;
        end
        @(negedge mclk);
        req_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 8) begin
            @(negedge mclk);
            n++;
        end
        check(n, (be == 2'b00) ? 0 : 3);
        if (!w) check(32'(rsp_rdata), 32'({be[1] ? m[15:8] : 8'h00, be[0] ? m[7:0] : 8'h00}));
        else ref_mem[a] = {16'h0000, be[1] ? d[15:8] : m[15:8], be[0] ? d[7:0] : m[7:0]};
        // a same-cycle answer leaves no edge between two requests
        if (n == 0) @(negedge mclk);
    endtask

    // watchdog
    initial begin
        #1000000;
        n_errors++;
        results();
    end

    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        ret_req = 1'b0;
        n_errors = 0;
        checked = 0;
        void'($urandom(89));
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        check(32'(pins), 32'(asramc_pkg::PINS_IDLE));
        check(32'({dq_oe, rsp_valid, ret_ready, req_ready}), 32'h01);
        rst = 1'b0;
        // random mixed traffic over a few words
        for (int i = 0; i < 60; i++) begin
            access(1'($urandom_range(0, 1)), 18'($urandom_range(0, 7)), 16'($urandom), 2'($urandom_range(0, 3)));
        end
        // every lane code at the top address, each read back whole
        for (int b = 0; b < 4; b++) begin
            access(1'b1, 18'h3ffff, 16'h5a5a ^ 16'(b * 16'h1111), 2'(b));
            access(1'b0, 18'h3ffff, 16'h0000, 2'b11);
        end
        // retention wins over a request, which stays refused
        ret_req = 1'b1;
        req_valid = 1'b1;
        req = '{write: 1'b1, addr: 18'h00001, wdata: 16'hdead, be: 2'b11};
        repeat (2) @(negedge mclk);
        for (int i = 0; i < 3; i++) begin
            check(32'({ret_ready, pins.chip_select_active_high, req_ready, rsp_valid}), 32'h8);
            @(negedge mclk);
        end
        req_valid = 1'b0;
        @(negedge mclk);
        ret_req = 1'b0;
        @(negedge mclk);
        check(32'({ret_ready, pins.chip_select_active_high, req_ready}), 32'h2);
        @(negedge mclk);
        check(32'(req_ready), 32'h1);
        // reset in mid-run leaves the array alone
        rst = 1'b1;
        @(negedge mclk);
        check(32'(pins), 32'(asramc_pkg::PINS_IDLE));
        rst = 1'b0;
        for (int i = 0; i < 8; i++) begin
            access(1'b0, 18'(i), 16'h0000, 2'b11);
        end
        results();
    end
endmodule // testbench
